// *** pstc_pkg.sv ***
// Purpose: Shared constants, register map and arithmetic helpers for the system time clock.
// Assumes: 250 MHz core clock, APB register access with 32-bit data.
// Notes:   Time counts are derived from the printed times and the clock period.
`default_nettype none

package pstc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int UPDATE_NS = 40;
    localparam int PHASE_NS = 8;
    localparam int CYC_PER_UPDATE = (UPDATE_NS * 1000) / CLK_PERIOD_PS;
    localparam int CYC_PER_PHASE = (PHASE_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0] CYC_LAST = 4'(CYC_PER_UPDATE - 1);
    localparam logic [3:0] PHASE_DIV_LAST = 4'(CYC_PER_PHASE - 1);

    // ------------------------------------------------------------
    // Counter limits and increments
    // ------------------------------------------------------------
    localparam logic [29:0] NS_WRAP = 30'h3b9aca00;
    localparam logic [31:0] SUBNS_LIMIT = 32'h0fffffff;
    localparam logic [29:0] NS_INC_SLOW = 30'h00000027;
    localparam logic [29:0] NS_INC_NOM = 30'h00000028;
    localparam logic [29:0] NS_INC_FAST = 30'h00000029;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL = 12'h600;
    localparam logic [11:0] ADDR_NANOSECONDS = 12'h604;
    localparam logic [11:0] ADDR_SECONDS = 12'h608;
    localparam logic [11:0] ADDR_SUB_PHASE = 12'h60c;
    localparam logic [11:0] ADDR_RATE = 12'h610;
    localparam logic [11:0] ADDR_DURATION = 12'h614;

    // Control register bit positions
    localparam int BIT_TIME_RESET = 0;
    localparam int BIT_TIME_ENABLE = 1;
    localparam int BIT_LOAD_TIME = 2;
    localparam int BIT_SNAPSHOT = 3;
    localparam int BIT_STEP_ADJUST = 4;
    localparam int BIT_STEP_DIR = 5;
    localparam int BIT_CONT_ADJUST = 6;
    localparam int BIT_RATE_DIR = 7;
    localparam int BIT_TIMED_ADJUST = 8;

    localparam logic [31:0] RESET_WORD = 32'h00000000;

    // Register selector from address decode
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_CONTROL = 3'h1,
        SEL_NANOSECONDS = 3'h2,
        SEL_SECONDS = 3'h3,
        SEL_SUB_PHASE = 3'h4,
        SEL_RATE = 3'h5,
        SEL_DURATION = 3'h6
    } pstc_sel_t;

    // Adds a delta to nanoseconds; bit 30 flags a wrap into the seconds
    function automatic logic [30:0] nsAdd(input logic [29:0] ns, input logic [29:0] delta);
        logic [30:0] sum;
        sum = {1'b0, ns} + {1'b0, delta};
        if (sum >= {1'b0, NS_WRAP}) begin
            nsAdd = {1'b1, 30'(sum - {1'b0, NS_WRAP})};
        end else begin
            nsAdd = sum;
        end
    endfunction : nsAdd

    // Subtracts a delta from nanoseconds; bit 30 flags a borrow from the seconds
    function automatic logic [30:0] nsSub(input logic [29:0] ns, input logic [29:0] delta);
        if (ns >= delta) begin
            nsSub = {1'b0, 30'(ns - delta)};
        end else begin
            nsSub = {1'b1, 30'(ns + NS_WRAP - delta)};
        end
    endfunction : nsSub

endpackage : pstc_pkg

`default_nettype wire

// *** pstc_core_if.sv ***
// Purpose: Carrier between register front end and time counter core.
// Assumes: Single clock domain; all signals are levels or one-cycle pulses.
// Notes:   The ctl side drives commands, the core side returns the running time.
`default_nettype none

interface pstc_core_if;
    logic timeReset;
    logic timeEnable;
    logic load;
    logic [31:0] loadSec;
    logic [29:0] loadNs;
    logic [2:0] loadPhase;
    logic clearPhase;
    logic step;
    logic stepAdd;
    logic [29:0] stepNs;
    logic rateApply;
    logic rateNeg;
    logic [31:0] rate;
    logic [31:0] sec;
    logic [29:0] ns;
    logic [31:0] subns;
    logic [2:0] phase;
    logic tick;

    modport ctl (
        output timeReset, timeEnable, load, loadSec, loadNs, loadPhase, clearPhase,
        output step, stepAdd, stepNs, rateApply, rateNeg, rate,
        input sec, ns, subns, phase, tick
    );
    modport core (
        input timeReset, timeEnable, load, loadSec, loadNs, loadPhase, clearPhase,
        input step, stepAdd, stepNs, rateApply, rateNeg, rate,
        output sec, ns, subns, phase, tick
    );
endinterface : pstc_core_if

`default_nettype wire

// *** pstc_time_core.sv ***
// Purpose: Running seconds, nanoseconds, sub-nanosecond and phase counters.
// Assumes: Commands arrive as one-cycle pulses from the register front end.
// Notes:   The 40 ns update and the step adjustment may land in the same cycle.
`default_nettype none

module pstc_time_core (
    input wire logic clk,
    input wire logic srst,
    pstc_core_if.core cif
);

    logic [3:0] cycCnt_q;
    logic [3:0] phDiv_q;
    logic [2:0] phase_q;
    logic [31:0] sec_q;
    logic [29:0] ns_q;
    logic [31:0] subns_q;
    logic tick;
    logic [32:0] subWide;
    logic [31:0] subns_d;
    logic subCarry;
    logic subBorrow;
    logic [29:0] nsInc;
    logic [30:0] afterTick;
    logic [30:0] afterStep;
    logic [31:0] sec_d;

    // ------------------------------------------------------------
    // Update interval and phase
    // ------------------------------------------------------------
    assign tick = cif.timeEnable && (cycCnt_q == pstc_pkg::CYC_LAST);

    // Interval counter and 8 ns phase counter
    always_ff @(posedge clk) begin
        if (srst || cif.timeReset || cif.clearPhase) begin
            cycCnt_q <= 4'h0;
            phDiv_q <= 4'h0;
            phase_q <= 3'h0;
        end else if (cif.load) begin
            cycCnt_q <= 4'(cif.loadPhase * pstc_pkg::CYC_PER_PHASE);
            phDiv_q <= 4'h0;
            phase_q <= cif.loadPhase;
        end else if (cif.timeEnable) begin
            if (tick) begin
                cycCnt_q <= 4'h0;
                phDiv_q <= 4'h0;
                phase_q <= 3'h0;
            end else begin
                cycCnt_q <= cycCnt_q + 4'h1;
                if (phDiv_q == pstc_pkg::PHASE_DIV_LAST) begin
                    phDiv_q <= 4'h0;
                    phase_q <= phase_q + 3'h1;
                end else begin
                    phDiv_q <= phDiv_q + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Next time value
    // ------------------------------------------------------------
    // Sub-nanosecond accumulation, nanosecond step and seconds carry
    always_comb begin
        subWide = 33'h0;
        subCarry = 1'b0;
        subBorrow = 1'b0;
        subns_d = subns_q;
        if (tick && cif.rateApply) begin
            if (!cif.rateNeg) begin
                subWide = {1'b0, subns_q} + {1'b0, cif.rate};
                if (subWide > {1'b0, pstc_pkg::SUBNS_LIMIT}) begin
                    subCarry = 1'b1;
                    subns_d = 32'(subWide - {1'b0, pstc_pkg::SUBNS_LIMIT} - 33'h1);
                end else begin
                    subns_d = subWide[31:0];
                end
            end else if (subns_q >= cif.rate) begin
                subns_d = subns_q - cif.rate;
            end else begin
                subBorrow = 1'b1;
                subWide = {1'b0, subns_q} + {1'b0, pstc_pkg::SUBNS_LIMIT} + 33'h1;
                subns_d = 32'(subWide - {1'b0, cif.rate});
            end
        end
        nsInc = subCarry ? pstc_pkg::NS_INC_FAST :
                (subBorrow ? pstc_pkg::NS_INC_SLOW : pstc_pkg::NS_INC_NOM);
        afterTick = tick ? pstc_pkg::nsAdd(ns_q, nsInc) : {1'b0, ns_q};
        afterStep = {1'b0, afterTick[29:0]};
        if (cif.step) begin
            afterStep = cif.stepAdd ? pstc_pkg::nsAdd(afterTick[29:0], cif.stepNs) :
                                      pstc_pkg::nsSub(afterTick[29:0], cif.stepNs);
        end
        sec_d = sec_q + {31'h0, afterTick[30]};
        if (cif.step && afterStep[30]) begin
            sec_d = cif.stepAdd ? sec_d + 32'h1 : sec_d - 32'h1;
        end
    end

    // Time registers
    always_ff @(posedge clk) begin
        if (srst || cif.timeReset) begin
            sec_q <= 32'h0;
            ns_q <= 30'h0;
            subns_q <= 32'h0;
        end else if (cif.load) begin
            sec_q <= cif.loadSec;
            ns_q <= cif.loadNs;
            subns_q <= 32'h0;
        end else begin
            sec_q <= sec_d;
            ns_q <= afterStep[29:0];
            subns_q <= subns_d;
        end
    end

    assign cif.sec = sec_q;
    assign cif.ns = ns_q;
    assign cif.subns = subns_q;
    assign cif.phase = phase_q;
    assign cif.tick = tick;

endmodule : pstc_time_core

`default_nettype wire

// *** pstc_system_time_clock.sv ***
// Purpose: APB register front end and adjustment control of the system time clock.
// Assumes: APB master holds each request until pready; one wait state per transfer.
// Notes:   Time register reads return the last snapshot, writes fill holding registers.
`default_nettype none

module pstc_system_time_clock (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] timeSec,
    output logic [29:0] timeNs,
    output logic [2:0] timePhase
);

    pstc_core_if cif ();

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Maps a byte address to a register selector
    function automatic pstc_pkg::pstc_sel_t decodeAddr(input logic [11:0] addr);
        if (addr == pstc_pkg::ADDR_CONTROL) begin
            decodeAddr = pstc_pkg::SEL_CONTROL;
        end else if (addr == pstc_pkg::ADDR_NANOSECONDS) begin
            decodeAddr = pstc_pkg::SEL_NANOSECONDS;
        end else if (addr == pstc_pkg::ADDR_SECONDS) begin
            decodeAddr = pstc_pkg::SEL_SECONDS;
        end else if (addr == pstc_pkg::ADDR_SUB_PHASE) begin
            decodeAddr = pstc_pkg::SEL_SUB_PHASE;
        end else if (addr == pstc_pkg::ADDR_RATE) begin
            decodeAddr = pstc_pkg::SEL_RATE;
        end else if (addr == pstc_pkg::ADDR_DURATION) begin
            decodeAddr = pstc_pkg::SEL_DURATION;
        end else begin
            decodeAddr = pstc_pkg::SEL_NONE;
        end
    endfunction : decodeAddr

    pstc_pkg::pstc_sel_t sel;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic wrEn;
    logic accessFirst;

    assign sel = decodeAddr(paddr);
    assign accessFirst = psel && penable && !pready_q;
    assign wrEn = psel && penable && pready_q && pwrite && (sel != pstc_pkg::SEL_NONE);

    // ------------------------------------------------------------
    // Software-visible registers
    // ------------------------------------------------------------
    logic timeEnable_q;
    logic stepDir_q;
    logic contAdj_q;
    logic rateDir_q;
    logic [31:0] wrSec_q;
    logic [29:0] wrNs_q;
    logic [15:0] wrPhase_q;
    logic [31:0] rate_q;
    logic [31:0] duration_q;

    // Control levels held in the control register
    always_ff @(posedge clk) begin
        if (srst) begin
            timeEnable_q <= 1'b0;
            stepDir_q <= 1'b0;
            contAdj_q <= 1'b0;
            rateDir_q <= 1'b0;
        end else if (wrEn && sel == pstc_pkg::SEL_CONTROL) begin
            timeEnable_q <= pwdata[pstc_pkg::BIT_TIME_ENABLE];
            stepDir_q <= pwdata[pstc_pkg::BIT_STEP_DIR];
            contAdj_q <= pwdata[pstc_pkg::BIT_CONT_ADJUST];
            rateDir_q <= pwdata[pstc_pkg::BIT_RATE_DIR];
        end
    end

    // Time holding registers written by software
    always_ff @(posedge clk) begin
        if (srst) begin
            wrSec_q <= pstc_pkg::RESET_WORD;
            wrNs_q <= 30'h0;
            wrPhase_q <= 16'h0;
        end else if (wrEn) begin
            if (sel == pstc_pkg::SEL_SECONDS) begin
                wrSec_q <= pwdata;
            end else if (sel == pstc_pkg::SEL_NANOSECONDS) begin
                wrNs_q <= pwdata[29:0];
            end else if (sel == pstc_pkg::SEL_SUB_PHASE) begin
                wrPhase_q <= pwdata[15:0];
            end
        end
    end

    // Rate and duration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            rate_q <= pstc_pkg::RESET_WORD;
            duration_q <= pstc_pkg::RESET_WORD;
        end else if (wrEn) begin
            if (sel == pstc_pkg::SEL_RATE) begin
                rate_q <= pwdata;
            end else if (sel == pstc_pkg::SEL_DURATION) begin
                duration_q <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Command pulses
    // ------------------------------------------------------------
    logic timeReset_q;
    logic load_q;
    logic snap_q;
    logic step_q;
    logic clearPhase_q;
    logic timedStart_q;
    logic ctlWr;

    assign ctlWr = wrEn && sel == pstc_pkg::SEL_CONTROL;

    // One-cycle pulses from self-clearing control bits and time writes
    always_ff @(posedge clk) begin
        if (srst) begin
            timeReset_q <= 1'b0;
            load_q <= 1'b0;
            snap_q <= 1'b0;
            step_q <= 1'b0;
            clearPhase_q <= 1'b0;
            timedStart_q <= 1'b0;
        end else begin
            timeReset_q <= ctlWr && pwdata[pstc_pkg::BIT_TIME_RESET];
            load_q <= ctlWr && pwdata[pstc_pkg::BIT_LOAD_TIME];
            snap_q <= ctlWr && pwdata[pstc_pkg::BIT_SNAPSHOT];
            step_q <= ctlWr && pwdata[pstc_pkg::BIT_STEP_ADJUST];
            timedStart_q <= ctlWr && pwdata[pstc_pkg::BIT_TIMED_ADJUST];
            clearPhase_q <= wrEn && (sel == pstc_pkg::SEL_SECONDS ||
                                     sel == pstc_pkg::SEL_NANOSECONDS);
        end
    end

    // ------------------------------------------------------------
    // Timed adjustment
    // ------------------------------------------------------------
    logic timedRun_q;
    logic [31:0] timedRate_q;
    logic [31:0] timedDur_q;

    // Duration counts down once per update interval while running
    always_ff @(posedge clk) begin
        if (srst || timeReset_q) begin
            timedRun_q <= 1'b0;
            timedRate_q <= pstc_pkg::RESET_WORD;
            timedDur_q <= pstc_pkg::RESET_WORD;
        end else if (timedStart_q) begin
            timedRun_q <= duration_q != 32'h0;
            timedRate_q <= rate_q;
            timedDur_q <= duration_q;
        end else if (timedRun_q && cif.tick) begin
            timedDur_q <= timedDur_q - 32'h1;
            if (timedDur_q == 32'h1) begin
                timedRun_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Snapshot
    // ------------------------------------------------------------
    logic [31:0] snapSec_q;
    logic [29:0] snapNs_q;
    logic [2:0] snapPhase_q;

    // Coherent capture of the running time
    always_ff @(posedge clk) begin
        if (srst) begin
            snapSec_q <= 32'h0;
            snapNs_q <= 30'h0;
            snapPhase_q <= 3'h0;
        end else if (snap_q) begin
            snapSec_q <= cif.sec;
            snapNs_q <= cif.ns;
            snapPhase_q <= cif.phase;
        end
    end

    // ------------------------------------------------------------
    // Core connection
    // ------------------------------------------------------------
    assign cif.timeReset = timeReset_q;
    assign cif.timeEnable = timeEnable_q;
    assign cif.load = load_q;
    assign cif.loadSec = wrSec_q;
    assign cif.loadNs = wrNs_q;
    assign cif.loadPhase = wrPhase_q[2:0];
    assign cif.clearPhase = clearPhase_q;
    assign cif.step = step_q;
    assign cif.stepAdd = stepDir_q;
    assign cif.stepNs = wrNs_q;
    // Timed adjustment takes priority over continuous adjustment
    assign cif.rateApply = timedRun_q || (contAdj_q && rate_q != 32'h0);
    assign cif.rateNeg = rateDir_q;
    assign cif.rate = timedRun_q ? timedRate_q : rate_q;

    pstc_time_core u_core (
        .clk(clk),
        .srst(srst),
        .cif(cif)
    );

    // ------------------------------------------------------------
    // APB read path and response
    // ------------------------------------------------------------
    logic [31:0] rdMux;

    // Read data selection
    always_comb begin
        rdMux = 32'h0;
        if (sel == pstc_pkg::SEL_CONTROL) begin
            rdMux[pstc_pkg::BIT_TIME_ENABLE] = timeEnable_q;
            rdMux[pstc_pkg::BIT_STEP_DIR] = stepDir_q;
            rdMux[pstc_pkg::BIT_CONT_ADJUST] = contAdj_q;
            rdMux[pstc_pkg::BIT_RATE_DIR] = rateDir_q;
            rdMux[pstc_pkg::BIT_TIMED_ADJUST] = timedRun_q;
        end else if (sel == pstc_pkg::SEL_NANOSECONDS) begin
            rdMux = {2'b00, snapNs_q};
        end else if (sel == pstc_pkg::SEL_SECONDS) begin
            rdMux = snapSec_q;
        end else if (sel == pstc_pkg::SEL_SUB_PHASE) begin
            rdMux = {29'h0, snapPhase_q};
        end else if (sel == pstc_pkg::SEL_RATE) begin
            rdMux = rate_q;
        end else if (sel == pstc_pkg::SEL_DURATION) begin
            rdMux = duration_q;
        end
    end

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (accessFirst) begin
            pready_q <= 1'b1;
            pslverr_q <= sel == pstc_pkg::SEL_NONE;
            prdata_q <= pwrite ? 32'h0 : rdMux;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign timeSec = cif.sec;
    assign timeNs = cif.ns;
    assign timePhase = cif.phase;

endmodule : pstc_system_time_clock

`default_nettype wire

// *** pstc_stc_asserts.sv ***
// Purpose: Port checks for the system time clock.
// Assumes: One clock, srst synchronous and active high.
// Notes:   Time step, wrap and phase sequence checks run only after the bus has been idle a while; range checks always run.
`default_nettype none
module pstc_stc_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] timeSec,
    input wire logic [29:0] timeNs,
    input wire logic [2:0] timePhase
);
    // ------------------------------------------------------------
    // Idle tracking
    // ------------------------------------------------------------
    logic [3:0] idleQ;
    // Counts cycles since the last select, saturating
    always_ff @(posedge clk) begin
        if (srst || psel) begin
            idleQ <= 4'h0;
        end else if (idleQ != 4'hf) begin
            idleQ <= idleQ + 4'h1;
        end
    end
    wire logic quiet = idleQ > 4'h5;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence setupS; psel && !penable; endsequence
    sequence answerS; ##1 (psel && penable && !pready) ##1 pready; endsequence
    a_ready_timing: assert property (setupS |-> answerS)
        else $error("pready not two cycles after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_phase_range: assert property (timePhase <= 3'h4)
        else $error("phase out of range");
    a_ns_range: assert property (timeNs < pstc_pkg::NS_WRAP)
        else $error("nanoseconds past wrap");
    a_ns_step: assert property (quiet && timeNs > $past(timeNs) |->
        (timeNs - $past(timeNs)) inside {30'h27, 30'h28, 30'h29})
        else $error("bad nanosecond step");
    a_sec_wrap: assert property (quiet && timeNs < $past(timeNs) |->
        timeNs < 30'h29 && timeSec == $past(timeSec) + 32'h1)
        else $error("bad seconds wrap");
    a_ns_phase_zero: assert property (quiet && $changed(timeNs) |-> timePhase == 3'h0)
        else $error("ns update not at phase zero");
    a_phase_hold: assert property (quiet && $changed(timePhase) |=> $stable(timePhase))
        else $error("phase held under 8 ns");
    a_phase_next: assert property (quiet && $changed(timePhase) |->
        timePhase == $past(timePhase) + 3'h1 || (timePhase == 3'h0 && $past(timePhase) == 3'h4))
        else $error("phase out of sequence");
endmodule : pstc_stc_asserts
bind pstc_system_time_clock pstc_stc_asserts u_chk (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .timeSec(timeSec),
    .timeNs(timeNs), .timePhase(timePhase));
`default_nettype wire

// *** precision_system_time_clock_tb.sv ***
// Purpose: Self-checking bench for the system time clock.
// Assumes: Time stands still after reset until enabled.
// Notes:   A rate of 0x10000000 forces a carry or borrow every interval.
`default_nettype none
module precision_system_time_clock_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, timeSec;
    logic pready, pslverr, err;
    logic [29:0] timeNs, d;
    logic [2:0] timePhase;
    int miscompares = 0;
    int checks_done = 0;
    localparam logic [29:0] W = pstc_pkg::NS_WRAP;
    // ------------------------------------------------------------
    // Clock, design and helpers
    // ------------------------------------------------------------
    always #2 clk = ~clk;
    pstc_system_time_clock DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .timeSec, .timeNs, .timePhase);
    task automatic summarize();
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One APB transfer, held until pready
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] v);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask : bus
    // Waits for the next nanosecond update and keeps its size
    task automatic nsStep();
        logic [29:0] p;
        int n;
        p = timeNs;
        n = 0;
        while (timeNs === p && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n == 40) begin
            miscompares++;
            summarize();
        end
        d = timeNs - p;
    endtask : nsStep
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic tUnmapped();
        bus(1'b0, 12'h700, 32'h00000000);
        check("slverr", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
    endtask : tUnmapped
    task automatic tLoadStep();
        bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h001);
        bus(1'b1, pstc_pkg::ADDR_SECONDS, 32'h5);
        bus(1'b1, pstc_pkg::ADDR_NANOSECONDS, {2'h0, W - 30'h64});
        bus(1'b1, pstc_pkg::ADDR_SUB_PHASE, 32'h3);
        bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h004);
        repeat (3) @(posedge clk);
        check("loaded sec", 32'h5, timeSec);
        check("loaded phase", 32'h3, {29'h0, timePhase});
        bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h008);
        bus(1'b1, pstc_pkg::ADDR_NANOSECONDS, 32'h3c);
        repeat (3) @(posedge clk);
        check("phase cleared", 32'h0, {29'h0, timePhase});
        bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h030);
        bus(1'b1, pstc_pkg::ADDR_NANOSECONDS, 32'h14);
        bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h010);
        bus(1'b0, pstc_pkg::ADDR_NANOSECONDS, 32'h0);
        check("snapshot ns", {2'h0, W - 30'h64}, rd);
        check("stepped ns", {2'h0, W - 30'h3c}, {2'h0, timeNs});
        bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h002);
        nsStep();
        nsStep();
        check("wrapped ns", 32'h14, {2'h0, timeNs});
        check("wrapped sec", 32'h6, timeSec);
    endtask : tLoadStep
    task automatic tRate();
        for (int r = 0; r < 3; r++) begin
            bus(1'b1, pstc_pkg::ADDR_RATE, (r == 2) ? 32'h0 : 32'h10000000);
            bus(1'b1, pstc_pkg::ADDR_CONTROL, (r == 1) ? 32'h0c2 : 32'h042);
            nsStep();
            nsStep();
            check("rate step", (r == 0) ? 32'h29 : (r == 1) ? 32'h27 : 32'h28, {2'h0, d});
        end
    endtask : tRate
    task automatic tTimed();
        bus(1'b1, pstc_pkg::ADDR_DURATION, 32'h3);
        bus(1'b1, pstc_pkg::ADDR_RATE, 32'h10000000);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h102);
            bus(1'b0, pstc_pkg::ADDR_CONTROL, 32'h0);
            check("timed running", 32'h1, {31'h0, rd[8]});
            nsStep();
            nsStep();
            check("timed rate", 32'h29, {2'h0, d});
            repeat (60) @(posedge clk);
            bus(1'b0, pstc_pkg::ADDR_CONTROL, 32'h0);
            check("timed done", 32'h0, {31'h0, rd[8]});
            nsStep();
            nsStep();
            check("timed ceased", 32'h28, {2'h0, d});
        end
        // Time reset bit clears the running time; the same write clears the enable bit and stops the clock
        bus(1'b1, pstc_pkg::ADDR_CONTROL, 32'h001);
        repeat (3) @(posedge clk);
        check("cleared sec", 32'h0, timeSec);
        check("cleared ns", 32'h0, {2'h0, timeNs});
    endtask : tTimed
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        check("reset ns", 32'h0, {2'h0, timeNs});
        tUnmapped();
        tLoadStep();
        tRate();
        tTimed();
        summarize();
    end
endmodule : precision_system_time_clock_tb
`default_nettype wire
